// ===== bench/core_memory_model.sv
// Behavioural core memory answering pointer reads and write-backs
`timescale 1ns/1ps
module core_memory_model
    import ea_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [WORD_W-1:0] mem_wdata,
    output logic [WORD_W-1:0] mem_rdata,
    output logic mem_ack
);
    // ------------------------------------------------------------
    // Storage and handshake
    // ------------------------------------------------------------
    logic [WORD_W-1:0] words [0:131071];
    logic [3:0] wait_cnt;

    // Ack one cycle after the counted wait; read data stand only in the ack cycle
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            wait_cnt <= 4'h0;
            mem_rdata <= 18'h2aaaa;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata; // Released line toggles, never holds stale data
        end else if (mem_rd || mem_wr) begin
            if (wait_cnt == wait_cycles) begin
                mem_ack <= 1'b1;
                wait_cnt <= 4'h0;
                if (mem_wr) begin
                    words[mem_addr] <= mem_wdata;
                end else begin
                    mem_rdata <= words[mem_addr];
                end
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
                mem_rdata <= ~mem_rdata;
            end
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule : core_memory_model

// ===== bench/effective_address_generator_tb_top.sv
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module effective_address_generator_tb_top;
    import ea_pkg::*;
    logic mclk, resetn, clk_en, bus_wr, bus_rd, program_start, console_bank_switch, pc_advance, start;
    logic mem_rd, mem_wr, mem_ack, ea_valid, busy, bank_mode;
    logic [BUS_ADDR_W-1:0] bus_addr;
    logic [WORD_W-1:0] bus_wdata, bus_rdata, instr, mem_wdata, mem_rdata, index_value;
    logic [ADDR_W-1:0] mem_addr, effective_address, pc_value;
    logic [3:0] wait_cycles;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    effective_address_generator i_effective_address_generator (.mclk, .resetn, .clk_en, .bus_addr, .bus_wdata,
        .bus_wr, .bus_rd, .bus_rdata, .program_start, .console_bank_switch, .pc_advance, .start, .instr,
        .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .effective_address, .ea_valid,
        .busy, .bank_mode, .pc_value, .index_value);
    core_memory_model i_core_memory_model (.mclk, .resetn, .wait_cycles, .mem_rd, .mem_wr, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack);

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        @(posedge mclk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge mclk);
        bus_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [17:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge mclk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, exp);
    endtask : rd
    // Opcode field is don't-care for addressing, fixed at 2
    function automatic logic [17:0] mk(input logic ind, input logic [12:0] fld);
        return {4'h2, ind, fld};
    endfunction : mk
    // Direct and indexed forms must finish in one cycle with no memory cycle
    task automatic ea(input logic [17:0] ins, input logic [16:0] exp, input logic ind);
        int n;
        @(posedge mclk);
        instr <= ins;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        #1;
        if (!ind) check({16'h0000, busy, mem_rd}, 18'h00000);
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check({17'h00000, ea_valid}, 18'h00001);
        check({1'b0, effective_address}, {1'b0, exp});
    endtask : ea
    task automatic adv(input logic [16:0] exp);
        @(posedge mclk);
        pc_advance <= 1'b1;
        @(posedge mclk);
        pc_advance <= 1'b0;
        #1;
        check({1'b0, pc_value}, {1'b0, exp});
    endtask : adv

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {resetn, bus_wr, bus_rd, program_start, console_bank_switch, pc_advance, start} = '0;
        clk_en = 1'b1;
        bus_addr = '0;
        bus_wdata = '0;
        instr = '0;
        wait_cycles = 4'h0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        rd(CTRL_OFFSET, 18'h00000);
        rd(PC_OFFSET, 18'h00000);
        rd(INDEX_OFFSET, 18'h00000);
        rd(EA_OFFSET, 18'h00000);
        rd(4'h2, 18'h00000);
        // Page mode direct, upper bits from the counter
        wr(PC_OFFSET, 18'h00040);
        ea(mk(1'b0, 13'h0492), 17'h00492, 1'b0);
        wr(PC_OFFSET, 18'h11600);
        ea(mk(1'b0, 13'h029c), 17'h1129c, 1'b0);
        // Indexed sums, positive, negative and full range
        wr(INDEX_OFFSET, 18'h00040);
        wr(PC_OFFSET, 18'h00600);
        ea(mk(1'b0, 13'h1040), 17'h00080, 1'b0);
        wr(PC_OFFSET, 18'h11600);
        wr(INDEX_OFFSET, 18'h0e000);
        ea(mk(1'b0, 13'h1200), 17'h1f200, 1'b0);
        wr(INDEX_OFFSET, 18'h2f000);
        ea(mk(1'b0, 13'h1200), 17'h00200, 1'b0);
        wr(INDEX_OFFSET, 18'h2f180);
        ea(mk(1'b0, 13'h1080), 17'h00200, 1'b0);
        wr(PC_OFFSET, 18'h00000);
        wr(INDEX_OFFSET, 18'h1ffff);
        ea(mk(1'b0, 13'h1000), 17'h1ffff, 1'b0);
        rd(INDEX_OFFSET, 18'h1ffff);
        // Indirect pointer keeps only the lower 32K part
        i_core_memory_model.words[17'h00249] = 18'h3f0c0;
        wr(PC_OFFSET, 18'h00080);
        ea(mk(1'b1, 13'h0249), 17'h070c0, 1'b1);
        // Auto-increment word: direct leaves it, indirect bumps it
        i_core_memory_model.words[17'h00008] = 18'h001ff;
        ea(mk(1'b0, 13'h0008), 17'h00008, 1'b0);
        check(i_core_memory_model.words[17'h00008], 18'h001ff);
        ea(mk(1'b1, 13'h0008), 17'h00200, 1'b1);
        check(i_core_memory_model.words[17'h00008], 18'h00200);
        // Bank mode from the console, slow memory from here on
        @(posedge mclk);
        wait_cycles <= 4'h3;
        console_bank_switch <= 1'b1;
        program_start <= 1'b1;
        @(posedge mclk);
        program_start <= 1'b0;
        #1;
        check({17'h00000, bank_mode}, 18'h00001);
        wr(PC_OFFSET, 18'h04100);
        ea(mk(1'b0, 13'h1abc), 17'h05abc, 1'b0);
        i_core_memory_model.words[17'h0000d] = 18'h2ffff;
        i_core_memory_model.words[17'h0400d] = 18'h01234;
        ea(mk(1'b1, 13'h000d), 17'h10000, 1'b1);
        check(i_core_memory_model.words[17'h0000d], 18'h30000);
        check(i_core_memory_model.words[17'h0400d], 18'h01234);
        ea(mk(1'b0, 13'h0008), 17'h04008, 1'b0);
        i_core_memory_model.words[17'h04249] = 18'h00123;
        ea(mk(1'b1, 13'h0249), 17'h00123, 1'b1);
        // Counter wraps inside the bank, but not in page mode
        wr(PC_OFFSET, 18'h05fff);
        adv(17'h04000);
        rd(PC_OFFSET, 18'h04000);
        wr(CTRL_OFFSET, 18'h00000);
        rd(CTRL_OFFSET, 18'h00004);
        wr(PC_OFFSET, 18'h05fff);
        adv(17'h06000);
        // Low clock enable freezes the counter
        @(posedge mclk);
        clk_en <= 1'b0;
        pc_advance <= 1'b1;
        @(posedge mclk);
        clk_en <= 1'b1;
        pc_advance <= 1'b0;
        #1;
        check({1'b0, pc_value}, 18'h06000);
        // Result register ignores writes
        wr(EA_OFFSET, 18'h3ffff);
        rd(EA_OFFSET, 18'h00123);
        give_verdict();
    end
endmodule : effective_address_generator_tb_top

// ===== rtl/ea_former.sv
// Combinational address forming for direct, indexed and auto-increment cases
`timescale 1ns/1ps
module ea_former
    import ea_pkg::*;
(
    input wire logic bank_mode,
    input wire logic [WORD_W-1:0] instr,
    input wire logic [ADDR_W-1:0] pc,
    input wire logic [WORD_W-1:0] index_value,
    output logic [ADDR_W-1:0] direct_addr,
    output logic [ADDR_W-1:0] indexed_addr,
    output logic [ADDR_W-1:0] autoinc_addr,
    output logic indirect,
    output logic indexed,
    output logic autoinc_hit
);
    logic [BANK_FIELD_W-1:0] offset;
    logic [WORD_W-1:0] index_sum;

    // ------------------------------------------------------------
    // Direct address and flag decode
    // ------------------------------------------------------------
    always_comb begin
        if (bank_mode) begin
            offset = instr[BANK_FIELD_W-1:0];
            direct_addr = {pc[ADDR_W-1:BANK_FIELD_W], instr[BANK_FIELD_W-1:0]};
        end else begin
            offset = {1'b0, instr[PAGE_FIELD_W-1:0]};
            direct_addr = {pc[ADDR_W-1:PAGE_FIELD_W], instr[PAGE_FIELD_W-1:0]};
        end
    end

    // Flags; indexing exists only in page mode
    assign indirect = instr[IND_BIT];
    assign indexed = !bank_mode && instr[IDX_BIT];

    // Offsets 10..17 hit from any page, bank or block; the pointer is always in page 0
    assign autoinc_hit = (offset[BANK_FIELD_W-1:AUTOINC_SEL_LSB] == AUTOINC_TAG);
    assign autoinc_addr = AUTOINC_BASE | {14'h0000, offset[AUTOINC_SEL_LSB-1:0]};

    // Full signed index plus page base and field, truncated to 17 bits
    assign index_sum = index_value + {1'b0, pc[ADDR_W-1:PAGE_FIELD_W], instr[PAGE_FIELD_W-1:0]};
    assign indexed_addr = index_sum[ADDR_W-1:0];
endmodule : ea_former

// ===== rtl/ea_pkg.sv
// Shared constants and types for the effective address generator
package ea_pkg;
    // ------------------------------------------------------------
    // Word and address geometry
    // ------------------------------------------------------------
    localparam int WORD_W = 18;
    localparam int ADDR_W = 17;
    localparam int BANK_FIELD_W = 13;
    localparam int PAGE_FIELD_W = 12;
    localparam int PTR_W = 15;
    localparam int BUS_ADDR_W = 4;
    // Instruction flag positions, bit k counted from the top sits at index 17-k
    localparam int IND_BIT = 13;
    localparam int IDX_BIT = 12;
    // Auto-increment window: offset field bits 12..3 equal one
    localparam int AUTOINC_SEL_LSB = 3;
    localparam logic [9:0] AUTOINC_TAG = 10'h001;
    localparam logic [ADDR_W-1:0] AUTOINC_BASE = 17'h00008;
    // ------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------
    localparam logic [BUS_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
    localparam logic [BUS_ADDR_W-1:0] INDEX_OFFSET = 4'h4;
    localparam logic [BUS_ADDR_W-1:0] PC_OFFSET = 4'h8;
    localparam logic [BUS_ADDR_W-1:0] EA_OFFSET = 4'hc;
    localparam int CTRL_BANK_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int CTRL_VALID_BIT = 2;
    localparam logic [ADDR_W-1:0] PC_RESET = 17'h00000;
    localparam logic [WORD_W-1:0] INDEX_RESET = 18'h00000;
    localparam logic BANK_MODE_RESET = 1'b0;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PTR_READ,
        ST_WRITE_BACK
    } ea_state_e;
endpackage : ea_pkg

// ===== rtl/effective_address_generator.sv
// Effective address generator with program counter, index register and pointer sequencer
// Behaviour
// - Direct field is bits 5-17 bank, 6-17 page
// - Instruction bit 4 selects indirect reference
// - Indirect pointer word reaches lower 32K; the auto-increment path keeps all 17 bits of the incremented word
// - Bank mode counter wraps inside its bank
// - Words 10-17 of page 0 auto-increment
// - Indirect auto-increment adds one, writes back first
// - Direct reference leaves auto-increment words alone
// - Offsets 10-17 anywhere hit page 0 pointers
// - Direct offsets 10-17 stay in own bank
// - Signed 18-bit index, 17-bit counter, 17-bit address
// - Indexing only page mode, no memory cycle
// - Indexed sum of index, counter page, field
// - Indexed addresses span all 131072 words
// - Negative index reaches below, sum truncated
// - Mode set by program or console at start
// - Page format opcode, indirect, index, 12-bit field
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module effective_address_generator
    import ea_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [BUS_ADDR_W-1:0] bus_addr,
    input wire logic [WORD_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [WORD_W-1:0] bus_rdata,
    input wire logic program_start,
    input wire logic console_bank_switch,
    input wire logic pc_advance,
    input wire logic start,
    input wire logic [WORD_W-1:0] instr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [ADDR_W-1:0] mem_addr,
    output logic [WORD_W-1:0] mem_wdata,
    input wire logic [WORD_W-1:0] mem_rdata,
    input wire logic mem_ack,
    output logic [ADDR_W-1:0] effective_address,
    output logic ea_valid,
    output logic busy,
    output logic bank_mode,
    output logic [ADDR_W-1:0] pc_value,
    output logic [WORD_W-1:0] index_value
);
    ea_state_e state_reg;
    logic autoinc_reg;
    logic [ADDR_W-1:0] direct_addr;
    logic [ADDR_W-1:0] indexed_addr;
    logic [ADDR_W-1:0] autoinc_addr;
    logic indirect;
    logic indexed;
    logic autoinc_hit;
    logic take;

    // ------------------------------------------------------------
    // Address forming
    // ------------------------------------------------------------
    ea_former u_former (
        .bank_mode(bank_mode),
        .instr(instr),
        .pc(pc_value),
        .index_value(index_value),
        .direct_addr(direct_addr),
        .indexed_addr(indexed_addr),
        .autoinc_addr(autoinc_addr),
        .indirect(indirect),
        .indexed(indexed),
        .autoinc_hit(autoinc_hit)
    );

    // Start is ignored while a pointer cycle is running
    assign take = clk_en && start && (state_reg == ST_IDLE);

    // ------------------------------------------------------------
    // Mode select
    // ------------------------------------------------------------
    // Console switch at program start wins over a same-cycle software write
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bank_mode <= BANK_MODE_RESET;
        end else if (clk_en) begin
            if (program_start) begin
                bank_mode <= console_bank_switch;
            end else if (bus_wr && bus_addr == CTRL_OFFSET) begin
                bank_mode <= bus_wdata[CTRL_BANK_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------
    // Load beats advance in the same cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pc_value <= PC_RESET;
        end else if (clk_en) begin
            if (bus_wr && bus_addr == PC_OFFSET) begin
                pc_value <= bus_wdata[ADDR_W-1:0];
            end else if (pc_advance && bank_mode) begin
                pc_value <= {pc_value[ADDR_W-1:BANK_FIELD_W],
                             pc_value[BANK_FIELD_W-1:0] + 13'h0001};
            end else if (pc_advance) begin
                pc_value <= pc_value + 17'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // Index register
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            index_value <= INDEX_RESET;
        end else if (clk_en && bus_wr && bus_addr == INDEX_OFFSET) begin
            index_value <= bus_wdata;
        end
    end

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    // Unmapped offsets read zero; data stand one cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= '0;
        end else if (clk_en) begin
            bus_rdata <= '0;
            if (bus_rd) begin
                case (bus_addr)
                    CTRL_OFFSET: begin
                        bus_rdata[CTRL_BANK_BIT] <= bank_mode;
                        bus_rdata[CTRL_BUSY_BIT] <= busy;
                        bus_rdata[CTRL_VALID_BIT] <= ea_valid;
                    end
                    INDEX_OFFSET: bus_rdata <= index_value;
                    PC_OFFSET: bus_rdata <= {1'b0, pc_value};
                    EA_OFFSET: bus_rdata <= {1'b0, effective_address};
                    default: bus_rdata <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Reference sequencer and memory port
    // ------------------------------------------------------------
    // Memory requests hold until mem_ack, so slow core just stretches the cycle
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            autoinc_reg <= 1'b0;
            busy <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            effective_address <= '0;
            ea_valid <= 1'b0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    if (take && indirect) begin
                        // Indexing beside indirect is not served here, pointer wins
                        ea_valid <= 1'b0;
                        busy <= 1'b1;
                        mem_rd <= 1'b1;
                        autoinc_reg <= autoinc_hit;
                        mem_addr <= autoinc_hit ? autoinc_addr : direct_addr;
                        state_reg <= ST_PTR_READ;
                    end else if (take && indexed) begin
                        effective_address <= indexed_addr;
                        ea_valid <= 1'b1;
                    end else if (take) begin
                        // Plain direct, even at offsets 10..17 of another bank
                        effective_address <= direct_addr;
                        ea_valid <= 1'b1;
                    end
                end
                ST_PTR_READ: begin
                    if (mem_ack && autoinc_reg) begin
                        mem_rd <= 1'b0;
                        mem_wr <= 1'b1;
                        mem_wdata <= mem_rdata + 18'h00001;
                        state_reg <= ST_WRITE_BACK;
                    end else if (mem_ack) begin
                        mem_rd <= 1'b0;
                        busy <= 1'b0;
                        effective_address <= {2'b00, mem_rdata[PTR_W-1:0]};
                        ea_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_WRITE_BACK: begin
                    // Address given only after the incremented word is stored
                    if (mem_ack) begin
                        mem_wr <= 1'b0;
                        busy <= 1'b0;
                        effective_address <= mem_wdata[ADDR_W-1:0];
                        ea_valid <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy <= 1'b0;
                    mem_rd <= 1'b0;
                    mem_wr <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_take_direct;
        take && !indirect && !indexed;
    endsequence

    sequence s_take_indexed;
        take && !indirect && indexed;
    endsequence

    sequence s_ptr_plain;
        clk_en && state_reg == ST_PTR_READ && mem_ack && !autoinc_reg;
    endsequence

    sequence s_ptr_autoinc;
        clk_en && state_reg == ST_PTR_READ && mem_ack && autoinc_reg;
    endsequence

    property p_direct;
        @(posedge mclk) disable iff (!resetn)
        s_take_direct |=> ea_valid && effective_address == $past(direct_addr) && !mem_rd && !mem_wr;
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");

    property p_direct_upper;
        @(posedge mclk) disable iff (!resetn)
        s_take_direct ##0 bank_mode |=>
            effective_address[ADDR_W-1:BANK_FIELD_W] == $past(pc_value[ADDR_W-1:BANK_FIELD_W]);
    endproperty
    a_direct_upper: assert property (p_direct_upper) else $error("direct bank bits wrong");

    property p_indexed;
        @(posedge mclk) disable iff (!resetn)
        s_take_indexed |=> ea_valid && !busy && !mem_rd &&
            effective_address == $past(index_value[ADDR_W-1:0] +
            {pc_value[ADDR_W-1:PAGE_FIELD_W], instr[PAGE_FIELD_W-1:0]});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_index_bank;
        @(posedge mclk) disable iff (!resetn)
        take && bank_mode && !indirect |=> effective_address == $past(direct_addr);
    endproperty
    a_index_bank: assert property (p_index_bank) else $error("indexing used in bank mode");

    property p_indirect_read;
        @(posedge mclk) disable iff (!resetn)
        take && indirect |=> mem_rd && busy && !ea_valid &&
            mem_addr == ($past(autoinc_hit) ? $past(autoinc_addr) : $past(direct_addr));
    endproperty
    a_indirect_read: assert property (p_indirect_read) else $error("pointer read missing");

    property p_pointer;
        @(posedge mclk) disable iff (!resetn)
        s_ptr_plain |=> ea_valid && !busy && effective_address == {2'b00, $past(mem_rdata[PTR_W-1:0])};
    endproperty
    a_pointer: assert property (p_pointer) else $error("pointer address wrong");

    property p_autoinc;
        @(posedge mclk) disable iff (!resetn)
        s_ptr_autoinc |=> mem_wr && !mem_rd && !ea_valid && mem_wdata == $past(mem_rdata) + 18'h00001;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("increment write wrong");

    property p_autoinc_addr;
        @(posedge mclk) disable iff (!resetn)
        take && indirect && autoinc_hit |=> mem_addr >= AUTOINC_BASE && mem_addr <= (AUTOINC_BASE | 17'h00007);
    endproperty
    a_autoinc_addr: assert property (p_autoinc_addr) else $error("pointer not in page 0");

    property p_bank_pc;
        @(posedge mclk) disable iff (!resetn)
        clk_en && pc_advance && bank_mode && !(bus_wr && bus_addr == PC_OFFSET) |=>
            pc_value[ADDR_W-1:BANK_FIELD_W] == $past(pc_value[ADDR_W-1:BANK_FIELD_W]);
    endproperty
    a_bank_pc: assert property (p_bank_pc) else $error("counter left its bank");

    property p_mode;
        @(posedge mclk) disable iff (!resetn)
        clk_en && program_start |=> bank_mode == $past(console_bank_switch);
    endproperty
    a_mode: assert property (p_mode) else $error("console mode not taken");
endmodule : effective_address_generator
